/* rtl/ppfs_pkg.sv */
// package: register map, field layout and routing codes of the pin function block
package ppfs_pkg;

    // register byte addresses on the wishbone slave
    localparam logic [4:0] ADDR_DRIVE    = 5'h00;
    localparam logic [4:0] ADDR_SEL_LOW  = 5'h04;
    localparam logic [4:0] ADDR_SEL_HIGH = 5'h08;
    localparam logic [4:0] ADDR_IN_ROUTE = 5'h0c;
    localparam logic [4:0] ADDR_DIR_A    = 5'h10;
    localparam logic [4:0] ADDR_PIN_A    = 5'h14;

    // values after reset
    localparam logic [7:0] RST_DRIVE = 8'h00;
    localparam logic [7:0] RST_SEL   = 8'h00;
    localparam logic [7:0] RST_ROUTE = 8'h00;
    localparam logic [7:0] RST_DIR   = 8'hff;
    localparam logic [7:0] RST_DOUT  = 8'h00;

    // writable bits of the drive, high selector and route registers; the rest read as zero
    localparam logic [7:0] MASK_DRIVE   = 8'h3f;
    localparam logic [7:0] MASK_SEL_HI  = 8'hc3;
    localparam logic [7:0] MASK_ROUTE   = 8'h1f;

    // field positions (low bit of each 2-bit field)
    localparam int UPPER_DRIVE_LSB = 4;
    localparam int LOWER_DRIVE_LSB = 2;
    localparam int PIN3_LSB = 6;
    localparam int PIN2_LSB = 4;
    localparam int PIN1_LSB = 2;
    localparam int PIN0_LSB = 0;
    localparam int PIN7_LSB = 6;
    localparam int PIN4_LSB = 0;

    // selector codes
    localparam logic [1:0] SEL_00 = 2'h0;
    localparam logic [1:0] SEL_01 = 2'h1;
    localparam logic [1:0] SEL_10 = 2'h2;
    localparam logic [1:0] SEL_11 = 2'h3;

    // what a port A pin carries
    typedef enum logic [2:0] {
        PPFS_GPIO     = 3'h0,
        PPFS_SPI_CS   = 3'h1,
        PPFS_UART_TX  = 3'h2,
        PPFS_SER_CLK  = 3'h3,
        PPFS_TMR_OUT  = 3'h4,
        PPFS_SER_DATA = 3'h5,
        PPFS_UART_1W  = 3'h6,
        PPFS_TMR_OUTN = 3'h7
    } ppfs_func_t;

    // outputs that peripherals drive onto pins
    typedef struct packed {
        logic spi_cs_n;
        logic spi_sck;
        logic spi_sdo;
        logic ser_data;
        logic uart_tx;
        logic tmr_out;
    } ppfs_periph_out_t;

    // pin-side view of port A
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } ppfs_pad_t;

endpackage : ppfs_pkg

/* rtl/ppfs_sync.sv */
// two flip-flop synchroniser for port A pad inputs
`timescale 1ns/10ps
module ppfs_sync (
    input  wire logic       clk_i,   // system clock
    input  wire logic       rst_i,   // synchronous reset
    input  wire logic [7:0] d_i,     // asynchronous pad levels
    output logic      [7:0] q_o      // synchronised levels
);
    logic [7:0] meta_q;

    // first stage is read only by the second stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= 8'h00;
            q_o    <= 8'h00;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule : ppfs_sync

/* rtl/ppfs_route.sv */
// combinational decode of port A selectors into pad and peripheral routing
`timescale 1ns/10ps
module ppfs_route (
    input  wire logic [7:0]                sel_low_i,  // low selector
    input  wire logic [7:0]                sel_high_i, // high selector
    input  wire logic [7:0]                dir_i,      // 1 = input
    input  wire logic [7:0]                dout_i,     // gpio out latch
    input  wire ppfs_pkg::ppfs_periph_out_t per_i,     // peripheral outputs
    output ppfs_pkg::ppfs_pad_t            pad_o       // pad drive
);
    // a code decoded to a function per pin
    function automatic ppfs_pkg::ppfs_func_t f(input logic [1:0] c,
        input ppfs_pkg::ppfs_func_t f1, input ppfs_pkg::ppfs_func_t f2,
        input ppfs_pkg::ppfs_func_t f3);
        case (c)
            ppfs_pkg::SEL_01: f = f1;
            ppfs_pkg::SEL_10: f = f2;
            ppfs_pkg::SEL_11: f = f3;
            default:          f = ppfs_pkg::PPFS_GPIO;
        endcase
    endfunction : f

    ppfs_pkg::ppfs_func_t fn [8];

    // pins 5 and 6 have no selector and stay general i/o
    always_comb begin
        fn[0] = f(sel_low_i[1:0], ppfs_pkg::PPFS_SER_DATA,
                  ppfs_pkg::PPFS_GPIO, ppfs_pkg::PPFS_GPIO);
        fn[1] = f(sel_low_i[3:2], ppfs_pkg::PPFS_TMR_OUT,
                  ppfs_pkg::PPFS_SER_DATA, ppfs_pkg::PPFS_UART_1W);
        fn[2] = f(sel_low_i[5:4], ppfs_pkg::PPFS_SER_CLK,
                  ppfs_pkg::PPFS_GPIO, ppfs_pkg::PPFS_GPIO);
        fn[3] = f(sel_low_i[7:6], ppfs_pkg::PPFS_SPI_CS,
                  ppfs_pkg::PPFS_UART_TX, ppfs_pkg::PPFS_GPIO);
        fn[4] = f(sel_high_i[1:0], ppfs_pkg::PPFS_SER_DATA,
                  ppfs_pkg::PPFS_UART_TX, ppfs_pkg::PPFS_GPIO);
        fn[5] = ppfs_pkg::PPFS_GPIO;
        fn[6] = ppfs_pkg::PPFS_GPIO;
        fn[7] = f(sel_high_i[7:6], ppfs_pkg::PPFS_TMR_OUTN,
                  ppfs_pkg::PPFS_SER_CLK, ppfs_pkg::PPFS_UART_1W);
        // pin 1 code 10 is spi data out, not the shared data line
        pad_o.out = 8'h00;
        pad_o.oe  = 8'h00;
        for (int i = 0; i < 8; i++) begin
            case (fn[i])
                ppfs_pkg::PPFS_SPI_CS:   pad_o.out[i] = per_i.spi_cs_n;
                ppfs_pkg::PPFS_UART_TX:  pad_o.out[i] = per_i.uart_tx;
                ppfs_pkg::PPFS_SER_CLK:  pad_o.out[i] = per_i.spi_sck;
                ppfs_pkg::PPFS_TMR_OUT:  pad_o.out[i] = per_i.tmr_out;
                ppfs_pkg::PPFS_TMR_OUTN: pad_o.out[i] = ~per_i.tmr_out;
                ppfs_pkg::PPFS_SER_DATA: pad_o.out[i] = (i == 1) ?
                                         per_i.spi_sdo : per_i.ser_data;
                ppfs_pkg::PPFS_UART_1W:  pad_o.out[i] = per_i.uart_tx;
                default:                 pad_o.out[i] = dout_i[i];
            endcase
            // gpio drives only when the direction bit is zero
            if (fn[i] == ppfs_pkg::PPFS_GPIO)
                pad_o.oe[i] = ~dir_i[i];
            else if (fn[i] == ppfs_pkg::PPFS_SER_DATA && i != 1)
                pad_o.oe[i] = 1'b0;
            else
                pad_o.oe[i] = 1'b1;
        end
    end
endmodule : ppfs_route

/* rtl/ppfs_top.sv */
// pin function select block: wishbone registers, port a routing, drive levels
// Summary of operation
// - bits 5:4 of drive register set PD7..PD4 source level, 00 min 11 max
// - bits 3:2 of drive register set PD3..PD0 source level 0..3
// - software-written selectors choose each shared pin's function
// - input route register holds five routing fields in bits 4:0
// - PA3 code 01 slave select, 10 uart transmit, else gpio with clock in
// - PA2 code 01 serial clock, else gpio
// - PA1 codes: gpio, timer out, spi data out, uart single wire
// - PA0 code 01 serial data in, else gpio
// - PA7 codes: gpio, inverted timer out, serial clock, uart
// - high selector bits 5:2 ignore writes and read zero
// - PA4 code 01 serial data, 10 uart transmit, else gpio with inputs
// - direction bit one makes pin input, zero makes cmos output
//
// The Wishbone slave port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module ppfs_top (
    input  wire logic        clk_i,        // 250 MHz system clock
    input  wire logic        rst_i,        // synchronous reset, high
    input  wire logic        wb_cyc_i,     // wishbone cycle
    input  wire logic        wb_stb_i,     // wishbone strobe
    input  wire logic        wb_we_i,      // wishbone write
    input  wire logic [4:0]  wb_adr_i,     // wishbone byte address
    input  wire logic [3:0]  wb_sel_i,     // wishbone byte enables
    input  wire logic [31:0] wb_dat_i,     // wishbone write data
    output logic      [31:0] wb_dat_o,     // wishbone read data
    output logic             wb_ack_o,     // wishbone acknowledge
    output logic             wb_err_o,     // unmapped address
    input  wire logic [7:0]  pa_pad_i,     // port a pad levels
    output logic      [7:0]  pa_pad_o,     // port a pad outputs
    output logic      [7:0]  pa_pad_oe_o,  // port a output enables
    input  wire ppfs_pkg::ppfs_periph_out_t per_i, // peripheral outputs
    output logic             spi_sdi_o,    // serial data into spi/i2c
    output logic             spi_sck_o,    // serial clock into spi/i2c
    output logic             uart_rx_o,    // uart receive input
    output logic             tmr_cap_o,    // timer capture input
    output logic             tmr_clk_o,    // timer clock input
    output logic             ext_int_o,    // external interrupt input
    output logic [1:0]       upper_group_drive_field_o, // PD7..PD4 level
    output logic [1:0]       lower_group_drive_field_o, // PD3..PD0 level
    output logic [4:0]       input_route_o // route fields to peripherals
);

    ////////////////////////////////////////////////////////////////////////
    // registers

    logic [7:0] port_d_drive_level_q;
    logic [7:0] port_a_func_sel_low_q;
    logic [7:0] port_a_func_sel_high_q;
    logic [7:0] input_route_register_q;
    logic [7:0] port_direction_register_q;
    logic [7:0] port_a_dout_q;
    logic [7:0] pa_sync;
    ppfs_pkg::ppfs_pad_t pad;
    logic       req;
    logic       wr_stb;
    logic       hit;
    logic [7:0] wbyte;
    logic [7:0] rd_d;

    // byte 0 write data, masked by its lane enable
    function automatic logic [7:0] merge(input logic [7:0] old,
        input logic [7:0] nw, input logic en, input logic [7:0] msk);
        merge = en ? (nw & msk) : old;
    endfunction : merge

    // new request is one not yet acknowledged; ack drops in the next cycle
    assign req    = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    assign wbyte  = wb_dat_i[7:0];
    assign hit    = (wb_adr_i == ppfs_pkg::ADDR_DRIVE)    |
                    (wb_adr_i == ppfs_pkg::ADDR_SEL_LOW)  |
                    (wb_adr_i == ppfs_pkg::ADDR_SEL_HIGH) |
                    (wb_adr_i == ppfs_pkg::ADDR_IN_ROUTE) |
                    (wb_adr_i == ppfs_pkg::ADDR_DIR_A)    |
                    (wb_adr_i == ppfs_pkg::ADDR_PIN_A);
    assign wr_stb = req & wb_we_i & hit;

    ////////////////////////////////////////////////////////////////////////
    // bus handshake: one-cycle answer, error for unmapped addresses

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
        end else begin
            wb_ack_o <= req & hit;
            wb_err_o <= req & ~hit;
        end
    end

    // drive register, unimplemented top bits held at zero
    always_ff @(posedge clk_i) begin
        if (rst_i)
            port_d_drive_level_q <= ppfs_pkg::RST_DRIVE;
        else if (wr_stb && wb_adr_i == ppfs_pkg::ADDR_DRIVE)
            port_d_drive_level_q <= merge(port_d_drive_level_q, wbyte,
                wb_sel_i[0], ppfs_pkg::MASK_DRIVE);
    end

    // port a selectors; the high one drops writes to bits 5:2
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_a_func_sel_low_q  <= ppfs_pkg::RST_SEL;
            port_a_func_sel_high_q <= ppfs_pkg::RST_SEL;
        end else if (wr_stb) begin
            if (wb_adr_i == ppfs_pkg::ADDR_SEL_LOW)
                port_a_func_sel_low_q <= merge(port_a_func_sel_low_q,
                    wbyte, wb_sel_i[0], 8'hff);
            if (wb_adr_i == ppfs_pkg::ADDR_SEL_HIGH)
                port_a_func_sel_high_q <= merge(port_a_func_sel_high_q,
                    wbyte, wb_sel_i[0], ppfs_pkg::MASK_SEL_HI);
        end
    end

    // input route register, bits 7:5 unused
    always_ff @(posedge clk_i) begin
        if (rst_i)
            input_route_register_q <= ppfs_pkg::RST_ROUTE;
        else if (wr_stb && wb_adr_i == ppfs_pkg::ADDR_IN_ROUTE)
            input_route_register_q <= merge(input_route_register_q, wbyte,
                wb_sel_i[0], ppfs_pkg::MASK_ROUTE);
    end

    // direction and output latch; direction resets to all inputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_direction_register_q <= ppfs_pkg::RST_DIR;
            port_a_dout_q             <= ppfs_pkg::RST_DOUT;
        end else if (wr_stb) begin
            if (wb_adr_i == ppfs_pkg::ADDR_DIR_A)
                port_direction_register_q <= merge(port_direction_register_q,
                    wbyte, wb_sel_i[0], 8'hff);
            if (wb_adr_i == ppfs_pkg::ADDR_PIN_A)
                port_a_dout_q <= merge(port_a_dout_q, wbyte,
                    wb_sel_i[0], 8'hff);
        end
    end

    // read mux; pin register shows pad level for inputs, latch for outputs
    always_comb begin
        rd_d = 8'h00;
        case (wb_adr_i)
            ppfs_pkg::ADDR_DRIVE:    rd_d = port_d_drive_level_q;
            ppfs_pkg::ADDR_SEL_LOW:  rd_d = port_a_func_sel_low_q;
            ppfs_pkg::ADDR_SEL_HIGH: rd_d = port_a_func_sel_high_q;
            ppfs_pkg::ADDR_IN_ROUTE: rd_d = input_route_register_q;
            ppfs_pkg::ADDR_DIR_A:    rd_d = port_direction_register_q;
            ppfs_pkg::ADDR_PIN_A:    rd_d = (pa_sync &
                                      port_direction_register_q) |
                                     (port_a_dout_q &
                                      ~port_direction_register_q);
            default:                 rd_d = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i)
            wb_dat_o <= 32'h0000_0000;
        else if (req)
            wb_dat_o <= {24'h00_0000, rd_d};
    end

    ////////////////////////////////////////////////////////////////////////
    // pad input synchroniser and routing decode

    ppfs_sync u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (pa_pad_i),
        .q_o   (pa_sync)
    );

    ppfs_route u_route (
        .sel_low_i  (port_a_func_sel_low_q),
        .sel_high_i (port_a_func_sel_high_q),
        .dir_i      (port_direction_register_q),
        .dout_i     (port_a_dout_q),
        .per_i      (per_i),
        .pad_o      (pad)
    );

    // registered pad drive: one cycle of latency traded for clean outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pa_pad_o    <= 8'h00;
            pa_pad_oe_o <= 8'h00;
        end else begin
            pa_pad_o    <= pad.out;
            pa_pad_oe_o <= pad.oe;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // peripheral inputs taken from pads; serial data, serial clock and uart receive per input route register bits
    // gpio-shared inputs are passed always; software must set the pin
    // as input, otherwise the pad only echoes its own output

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            spi_sdi_o <= 1'b0;
            spi_sck_o <= 1'b0;
            uart_rx_o <= 1'b0;
            tmr_cap_o <= 1'b0;
            tmr_clk_o <= 1'b0;
            ext_int_o <= 1'b0;
        end else begin
            // serial data in: PA4 when its route bit is set, else PA0
            spi_sdi_o <= input_route_register_q[4] ? pa_sync[4] : pa_sync[0];
            // serial clock in: PA7 when route bit set, else PA2
            spi_sck_o <= input_route_register_q[3] ? pa_sync[7] : pa_sync[2];
            // uart receive: PA7 when route bit set, else PA1
            uart_rx_o <= input_route_register_q[2] ? pa_sync[7] : pa_sync[1];
            tmr_cap_o <= pa_sync[4];
            tmr_clk_o <= pa_sync[3];
            ext_int_o <= pa_sync[4];
        end
    end

    // drive fields and route fields out to pads and peripherals
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            upper_group_drive_field_o <= 2'h0;
            lower_group_drive_field_o <= 2'h0;
            input_route_o             <= 5'h00;
        end else begin
            upper_group_drive_field_o <= port_d_drive_level_q[
                ppfs_pkg::UPPER_DRIVE_LSB +: 2];
            lower_group_drive_field_o <= port_d_drive_level_q[
                ppfs_pkg::LOWER_DRIVE_LSB +: 2];
            input_route_o <= input_route_register_q[4:0];
        end
    end

endmodule : ppfs_top

/* test/ppfs_top_asserts.sv */
// concurrent checks on the ports of the pin function select block
`timescale 1ns/10ps
module ppfs_top_asserts (
    input wire logic        clk_i,        // system clock
    input wire logic        rst_i,        // synchronous reset
    input wire logic        wb_cyc_i,     // wishbone cycle
    input wire logic        wb_stb_i,     // wishbone strobe
    input wire logic        wb_we_i,      // wishbone write
    input wire logic [4:0]  wb_adr_i,     // byte address
    input wire logic [3:0]  wb_sel_i,     // byte enables
    input wire logic [31:0] wb_dat_i,     // write data
    input wire logic [31:0] wb_dat_o,     // read data
    input wire logic        wb_ack_o,     // acknowledge
    input wire logic        wb_err_o,     // unmapped address
    input wire logic [7:0]  pa_pad_o,     // pad outputs
    input wire logic [7:0]  pa_pad_oe_o,  // pad output enables
    input wire ppfs_pkg::ppfs_periph_out_t per_i, // peripheral outputs
    input wire logic [1:0]  upper_group_drive_field_o, // PD7..PD4 level
    input wire logic [1:0]  lower_group_drive_field_o, // PD3..PD0 level
    input wire logic [4:0]  input_route_o // route fields
);
    logic       take;
    logic [7:0] lo_q;
    logic [7:0] hi_q;
    // a request is taken only while no answer is standing
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    // shadow selectors: the registers themselves are not visible here
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lo_q <= 8'h00;
            hi_q <= 8'h00;
        end else if (take && wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i == ppfs_pkg::ADDR_SEL_LOW)
                lo_q <= wb_dat_i[7:0];
            if (wb_adr_i == ppfs_pkg::ADDR_SEL_HIGH)
                hi_q <= wb_dat_i[7:0];
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_wr(logic [4:0] a);
        take && wb_we_i && wb_sel_i[0] && wb_adr_i == a;
    endsequence
    sequence s_rd(logic [4:0] a);
        take && !wb_we_i && wb_adr_i == a;
    endsequence
    property p_ack_pulse;
        (wb_ack_o || wb_err_o) |=> !(wb_ack_o || wb_err_o);
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("answer longer than one cycle");
    property p_answer;
        take |=> wb_ack_o != wb_err_o;
    endproperty
    a_answer: assert property (p_answer) else $error("request not answered");
    // field ports are registered behind the register: two edges late
    property p_upper;
        s_wr(ppfs_pkg::ADDR_DRIVE) |-> ##2
            upper_group_drive_field_o == $past(wb_dat_i[5:4], 2);
    endproperty
    a_upper: assert property (p_upper) else $error("upper drive field wrong");
    property p_lower;
        s_wr(ppfs_pkg::ADDR_DRIVE) |-> ##2
            lower_group_drive_field_o == $past(wb_dat_i[3:2], 2);
    endproperty
    a_lower: assert property (p_lower) else $error("lower drive field wrong");
    property p_route;
        s_wr(ppfs_pkg::ADDR_IN_ROUTE) |-> ##2
            input_route_o == $past(wb_dat_i[4:0], 2);
    endproperty
    a_route: assert property (p_route) else $error("route fields wrong");
    property p_hi_zero;
        s_rd(ppfs_pkg::ADDR_SEL_HIGH) |=> wb_dat_o[5:2] == 4'h0;
    endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("unused selector bits read");
    property p_pa3_cs;
        $past(lo_q[7:6]) == 2'h1 |-> pa_pad_oe_o[3] && pa_pad_o[3] == $past(per_i.spi_cs_n);
    endproperty
    a_pa3_cs: assert property (p_pa3_cs) else $error("PA3 not slave select");
    property p_pa0_in;
        $past(lo_q[1:0]) == 2'h1 |-> !pa_pad_oe_o[0];
    endproperty
    a_pa0_in: assert property (p_pa0_in) else $error("PA0 driven as serial in");
    property p_pa7_inv;
        $past(hi_q[7:6]) == 2'h1 |-> pa_pad_oe_o[7] && pa_pad_o[7] == !$past(per_i.tmr_out);
    endproperty
    a_pa7_inv: assert property (p_pa7_inv) else $error("PA7 not inverted timer");
endmodule : ppfs_top_asserts

bind ppfs_top ppfs_top_asserts i_asserts (.*);

/* test/ppfs_far_model.sv */
// far side model: peripheral outputs and resolved port a pin levels
`timescale 1ns/10ps
module ppfs_far_model (
    input  wire logic       clk_i,  // system clock
    input  wire logic       en_i,   // peripherals enabled
    input  wire logic [5:0] val_i,  // levels the peripherals drive
    input  wire logic [7:0] ext_i,  // outside drivers on the pins
    input  wire logic [7:0] pad_i,  // block pad outputs
    input  wire logic [7:0] oe_i,   // block pad output enables
    output ppfs_pkg::ppfs_periph_out_t per_o, // peripheral outputs
    output logic      [7:0] lvl_o   // resolved pin levels
);
    // a disabled peripheral idles with select high, the rest low
    always_ff @(posedge clk_i) begin
        per_o <= ppfs_pkg::ppfs_periph_out_t'(en_i ? val_i : 6'h20);
    end
    // the block wins where it drives, the outside world elsewhere
    assign lvl_o = (oe_i & pad_i) | (~oe_i & ext_i);
endmodule : ppfs_far_model

/* test/testbench.sv */
// self-checking bench for the pin function select block
`timescale 1ns/10ps
module testbench;
    localparam logic [4:0] REGS [4] = '{ppfs_pkg::ADDR_DRIVE,
        ppfs_pkg::ADDR_SEL_LOW, ppfs_pkg::ADDR_SEL_HIGH, ppfs_pkg::ADDR_IN_ROUTE};
    localparam logic [7:0] MASKS [4] = '{ppfs_pkg::MASK_DRIVE, 8'hff,
        ppfs_pkg::MASK_SEL_HI, ppfs_pkg::MASK_ROUTE};
    logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic        en = 1'b0, ack, err, sdi, sck, rx, cap, tck, eint;
    logic [4:0]  adr = 5'h00, route, r;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0, dat_o;
    logic [7:0]  ext = 8'h00, pad_o, oe, lvl, lo, hi, dir, dq, pl;
    logic [5:0]  val = 6'h00;
    logic [1:0]  up, lw;
    logic [33:0] notes [$];
    logic [33:0] nt;
    int          num_errors = 0, samples_checked = 0, cycles = 0;
    ppfs_pkg::ppfs_periph_out_t per;

    always #2 clk = ~clk;
    ppfs_top i_dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err), .pa_pad_i(lvl),
        .pa_pad_o(pad_o), .pa_pad_oe_o(oe), .per_i(per), .spi_sdi_o(sdi),
        .spi_sck_o(sck), .uart_rx_o(rx), .tmr_cap_o(cap), .tmr_clk_o(tck),
        .ext_int_o(eint), .upper_group_drive_field_o(up),
        .lower_group_drive_field_o(lw), .input_route_o(route));
    ppfs_far_model i_far (.clk_i(clk), .en_i(en), .val_i(val), .ext_i(ext),
        .pad_i(pad_o), .oe_i(oe), .per_o(per), .lvl_o(lvl));
    ////////////////////////////////////////
    task automatic cmp(input string nm, input logic [32:0] e, g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp
    // only pins the block drives have a defined output value
    task automatic cmp_pad(input logic [15:0] e);
        samples_checked++;
        if (oe !== e[15:8] || ((pad_o ^ e[7:0]) & e[15:8]) !== 8'h00) begin
            num_errors++;
            $display("[FAIL] pads expected %h seen %h", e, {oe, pad_o});
        end
    endtask : cmp_pad
    // note: [33] data checked, [32] error expected, [31:0] read data
    task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d,
        input logic [33:0] n);
        notes.push_back(n);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        sel <= 4'h1;
        dat <= {24'h0, d};
        do begin
            @(posedge clk);
        end while (ack !== 1'b1 && err !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : wb
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        wb(1'b1, a, d, 34'h0);
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00, {2'b10, 24'h0, e});
    endtask : rd
    // pin {oe,out}: z marks input codes, m driven codes with value v
    function automatic logic [1:0] pin(input int b, input logic [1:0] c,
        input logic [3:0] m, z, v);
        if (z[c])
            return 2'b00;
        if (m[c])
            return {1'b1, v[c]};
        return {~dir[b], dq[b]};
    endfunction : pin
    function automatic logic [15:0] pad_exp();
        logic [1:0]  p [8];
        logic [15:0] e;
        p[0] = pin(0, lo[1:0], 4'h0, 4'h2, 4'h0);
        p[1] = pin(1, lo[3:2], 4'he, 4'h0,
            {per.uart_tx, per.spi_sdo, per.tmr_out, 1'b0});
        p[2] = pin(2, lo[5:4], 4'h2, 4'h0, {2'h0, per.spi_sck, 1'b0});
        p[3] = pin(3, lo[7:6], 4'h6, 4'h0,
            {1'b0, per.uart_tx, per.spi_cs_n, 1'b0});
        p[4] = pin(4, hi[1:0], 4'h4, 4'h2, {1'b0, per.uart_tx, 2'h0});
        p[5] = pin(5, 2'h0, 4'h0, 4'h0, 4'h0);
        p[6] = pin(6, 2'h0, 4'h0, 4'h0, 4'h0);
        p[7] = pin(7, hi[7:6], 4'he, 4'h0,
            {per.uart_tx, per.spi_sck, ~per.tmr_out, 1'b0});
        for (int i = 0; i < 8; i++) begin
            e[8 + i] = p[i][1];
            e[i] = p[i][0];
        end
        return e;
    endfunction : pad_exp
    // answers are matched in order against the notes of the driver
    always @(posedge clk) begin
        if (ack === 1'b1 || err === 1'b1) begin
            nt = notes.pop_front();
            cmp("wb err", {32'h0, nt[32]}, {32'h0, err});
            if (nt[33])
                cmp("wb data", {1'b0, nt[31:0]}, {1'b0, dat_o});
        end
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : print_verdict
    // a hang is cut short far beyond the few hundred cycles needed
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            print_verdict();
        end
    end
    ////////////////////////////////////////
    initial begin
        void'($urandom(3192));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 4; i++)
            rd(REGS[i], 8'h00);
        rd(ppfs_pkg::ADDR_DIR_A, ppfs_pkg::RST_DIR);
        cmp("reset fields", 33'h0, {8'h0, pad_o, oe, up, lw, route});
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            wr(REGS[i], 8'hff);
            rd(REGS[i], MASKS[i]);
        end
        for (int c = 0; c < 4; c++) begin
            wr(ppfs_pkg::ADDR_DRIVE, {2'h3, 2'(c), 2'(3 - c), 2'h3});
            cmp("drive", {29'h0, 2'(c), 2'(3 - c)}, {29'h0, up, lw});
        end
        $display("test registers done");
        for (int k = 0; k < 24; k++) begin
            en <= 1'b0; // peripheral off before reselecting
            @(posedge clk);
            lo = (k < 4) ? {4{2'(k)}} : 8'($urandom);
            hi = (k < 4) ? {2'(k), 4'h0, 2'(k)} : 8'($urandom);
            dir = (k < 4) ? 8'h00 : 8'($urandom);
            dq = 8'($urandom);
            wr(ppfs_pkg::ADDR_SEL_LOW, lo); // selector first
            wr(ppfs_pkg::ADDR_SEL_HIGH, hi);
            wr(ppfs_pkg::ADDR_DIR_A, dir);
            wr(ppfs_pkg::ADDR_PIN_A, dq);
            val <= 6'($urandom);
            en <= 1'b1; // then enable the peripheral
            repeat (4) @(posedge clk);
            cmp_pad(pad_exp());
        end
        $display("test routing done");
        wr(ppfs_pkg::ADDR_SEL_LOW, 8'h00);
        wr(ppfs_pkg::ADDR_SEL_HIGH, 8'h00);
        for (int k = 0; k < 6; k++) begin
            dir = 8'($urandom) | 8'h18; // timer clock and capture pins PA3 and PA4 as inputs
            dq = 8'($urandom);
            r = 5'($urandom);
            wr(ppfs_pkg::ADDR_DIR_A, dir);
            wr(ppfs_pkg::ADDR_PIN_A, dq);
            wr(ppfs_pkg::ADDR_IN_ROUTE, {3'h0, r});
            ext <= 8'($urandom);
            repeat (5) @(posedge clk);
            pl = (ext & dir) | (dq & ~dir);
            rd(ppfs_pkg::ADDR_PIN_A, pl);
            cmp("route", {28'h0, r}, {28'h0, route});
            cmp("inputs", {27'h0, pl[3], pl[4], pl[4], r[4] ? pl[4] : pl[0],
                r[3] ? pl[7] : pl[2], r[2] ? pl[7] : pl[1]},
                {27'h0, tck, cap, eint, sdi, sck, rx});
        end
        $display("test inputs done");
        wb(1'b0, 5'h18, 8'h00, {2'b11, 32'h0});
        wb(1'b1, 5'h1c, 8'h5a, {2'b11, 32'h0});
        rd(ppfs_pkg::ADDR_SEL_LOW, 8'h00);
        $display("test unmapped done");
        print_verdict();
    end
endmodule : testbench
